// ---- core/ohd_cfg.svh ----
// Constants for the display command decoder: codes, fields, reset values.
// Included by the package user; definitions only.
`ifndef OHD_CFG_SVH
`define OHD_CFG_SVH
`define OHD_CMD_MODE 8'h20
`define OHD_CMD_COLS 8'h21
`define OHD_CMD_PAGES 8'h22
`define OHD_CMD_CONTRAST 8'h81
`define OHD_CMD_BRIGHT 8'h82
`define OHD_CMD_LUT 8'h91
`define OHD_CMD_BANK_LO 8'h92
`define OHD_CMD_BANK_HI 8'h93
`define OHD_RST_MODE 2'h2
`define OHD_RST_COL_END 8'h83
`define OHD_RST_PAGE_END 3'h7
`define OHD_RST_LEVEL 8'h80
`define OHD_RST_LUT_BANK0 6'h31
`define OHD_RST_LUT_COLOR 6'h3F
`define OHD_COLOR_D_WIDTH 7'h40
`define OHD_I2C_ADDR_BASE 7'h3C
`endif

// ---- core/ohd_pkg.sv ----
// Types for the display command decoder.
// Assumes nothing of its surroundings.
package ohd_pkg;
  typedef enum logic [1:0] {
    OHD_PORT_SERIAL = 2'h0,
    OHD_PORT_I2C = 2'h1,
    OHD_PORT_6800 = 2'h2,
    OHD_PORT_8080 = 2'h3
  } ohd_port_t;
  typedef enum logic [1:0] {
    OHD_I2C_IDLE = 2'h0,
    OHD_I2C_ADDR = 2'h1,
    OHD_I2C_CTRL = 2'h2,
    OHD_I2C_DATA = 2'h3
  } ohd_i2c_t;
endpackage : ohd_pkg

// ---- core/ohd_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module ohd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be 2^n");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic push, pop;
  always_comb begin
    in_ready_o = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    out_valid_o = wr_ptr != rd_ptr;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    next_wr_ptr = wr_ptr + (AW+1)'(push);
    next_rd_ptr = rd_ptr + (AW+1)'(pop);
    out_data_o = mem[rd_ptr[AW-1:0]];
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule : ohd_fifo

// ---- core/ohd_decoder.sv ----
// Host port intake and command decoder for a small OLED controller.
// Assumes all pins are asynchronous to clock_i and are synchronised here.
// What this block does
// - Command/data line low means command byte, high means display data; in I2C mode bit 6 of the control byte decides instead.
// - Two straps pick 6800, 8080, 4-wire serial or I2C host port.
// - In 8080 mode write and read strobes are separate active-low pins.
// - In 6800 mode direction high requests read, low requests write.
// - In 6800 mode the transfer happens on enable's falling edge.
// - Serial bits shift MSB first on rising clock; byte commits every eighth.
// - I2C data is taken from the input pin; output may be unconnected.
// - Address-select pin sets the least significant bit of I2C address.
// - Answer only to 0111100 with pin low, 0111101 with pin high.
// - Reset pin low restores every command parameter to its default.
// - Codes 00-0F load lower nibble of page-mode column start.
// - Codes 10-1F load upper nibble of page-mode column start.
// - Command 20 sets addressing mode; 11 invalid; default page mode.
// - Command 21 sets column start and end, defaults 0 and 131.
// - Command 22 sets page start and end, defaults 0 and 7.
// - Codes 40-7F set display start line, default 0.
// - Command 81 sets contrast, default 0x80.
// - Command 82 sets brightness, default 0x80.
// - Command 91 sets four 6-bit pulse widths; defaults 0x31 and 0x3F.
// - Colour D pulse width is fixed at 64 clocks.
// - Command 92 assigns colours to banks 1-16, two bits each, low first.
// - Command 93 assigns colours to banks 17-32 the same way.
`timescale 1ns/1ps
`include "ohd_cfg.svh"
module ohd_decoder import ohd_pkg::*; #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Port straps and shared control
  input wire logic port_strap_lo_i,
  input wire logic port_strap_hi_i,
  input wire logic chip_sel_n_i,
  input wire logic cmd_data_i,
  input wire logic addr_lsb_pin_i,
  // Parallel strobes (8080: write/read low; 6800: direction/enable)
  input wire logic wr_pin_i,
  input wire logic rd_pin_i,
  // Data bus, serial clock on bit 0, serial data on bit 1
  input wire logic [7:0] bus_lines_i,
  output logic [7:0] bus_lines_o,
  output logic bus_lines_oe_o,
  output logic sda_out_o,
  output logic sda_out_oe_o,
  // Display data stream
  output logic pix_valid_o,
  input wire logic pix_ready_i,
  output logic [7:0] pix_data_o,
  // Command-set state
  output logic [1:0] addr_mode_o,
  output logic [7:0] page_col_start_o,
  output logic [7:0] col_start_o,
  output logic [7:0] col_end_o,
  output logic [2:0] page_start_o,
  output logic [2:0] page_end_o,
  output logic [5:0] start_line_o,
  output logic [7:0] contrast_o,
  output logic [7:0] brightness_o,
  output logic [5:0] lut_bank0_o,
  output logic [5:0] lut_color_a_o,
  output logic [5:0] lut_color_b_o,
  output logic [5:0] lut_color_c_o,
  output logic [6:0] lut_color_d_o,
  output logic [63:0] bank_color_o
);
  initial begin
    if (FIFO_DEPTH != 8) $error("FIFO_DEPTH must stay 8");
  end
  // Two-stage synchronisers for every pin
  localparam int NS = 15;
  // Reset to idle pin levels so no false strobe edge follows reset
  localparam logic [NS-1:0] PIN_IDLE = 15'h1300;
  logic [NS-1:0] pins, s1, s2, s3;
  assign pins = {port_strap_lo_i, port_strap_hi_i, chip_sel_n_i, cmd_data_i,
                 addr_lsb_pin_i, wr_pin_i, rd_pin_i, bus_lines_i};
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1 <= PIN_IDLE;
      s2 <= PIN_IDLE;
      s3 <= PIN_IDLE;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
    end
  end
  logic cs_n, dc, sa0, wrp, rdp, wrp_d, rdp_d;
  logic [7:0] bus;
  ohd_port_t port;
  assign port = ohd_port_t'({s2[13], s2[14]});
  assign cs_n = s2[12];
  assign dc = s2[11];
  assign sa0 = s2[10];
  assign wrp = s2[9];
  assign rdp = s2[8];
  assign wrp_d = s3[9];
  assign rdp_d = s3[8];
  assign bus = s2[7:0];
  logic scl, scl_d, sdi, sdi_d;
  assign scl = bus[0];
  assign scl_d = s3[0];
  assign sdi = bus[1];
  assign sdi_d = s3[1];

  // Byte intake from the selected port
  logic byte_stb, byte_dc;
  logic [7:0] byte_val;
  logic [7:0] sh, next_sh;
  logic [3:0] cnt, next_cnt;
  ohd_i2c_t ist, next_ist;
  logic ack, next_ack, i2c_dc, next_i2c_dc, i2c_cont, next_i2c_cont;
  logic scl_rise, scl_fall, i2c_start, i2c_stop;
  always_comb begin
    scl_rise = scl && !scl_d;
    scl_fall = !scl && scl_d;
    i2c_start = scl && scl_d && sdi_d && !sdi;
    i2c_stop = scl && scl_d && !sdi_d && sdi;
    byte_stb = 1'b0;
    byte_dc = dc;
    byte_val = bus;
    next_sh = sh;
    next_cnt = cnt;
    next_ist = ist;
    next_ack = ack;
    next_i2c_dc = i2c_dc;
    next_i2c_cont = i2c_cont;
    unique case (port)
      OHD_PORT_8080: byte_stb = !cs_n && wrp && !wrp_d;
      OHD_PORT_6800: byte_stb = !cs_n && !wrp && !rdp && rdp_d;
      OHD_PORT_SERIAL: begin
        if (cs_n) begin
          next_cnt = '0;
        end else if (scl_rise) begin
          next_sh = {sh[6:0], sdi};
          next_cnt = (cnt == 4'h7) ? 4'h0 : cnt + 4'h1;
          byte_stb = cnt == 4'h7;
          byte_val = {sh[6:0], sdi};
        end
      end
      OHD_PORT_I2C: begin
        byte_dc = i2c_dc;
        byte_val = sh;
        if (i2c_start) begin
          next_ist = OHD_I2C_ADDR;
          next_cnt = '0;
          next_ack = 1'b0;
        end else if (i2c_stop) begin
          next_ist = OHD_I2C_IDLE;
          next_ack = 1'b0;
        end else if (ist != OHD_I2C_IDLE && scl_rise && cnt != 4'h8) begin
          next_sh = {sh[6:0], sdi};
          next_cnt = cnt + 4'h1;
        end else if (ist != OHD_I2C_IDLE && scl_fall) begin
          if (cnt == 4'h8 && !ack) begin
            next_ack = 1'b1;
            unique case (ist)
              OHD_I2C_ADDR: begin
                if (sh[7:1] != (`OHD_I2C_ADDR_BASE | {6'h0, sa0})) begin
                  next_ist = OHD_I2C_IDLE;
                  next_ack = 1'b0;
                end else begin
                  next_ist = OHD_I2C_CTRL;
                end
              end
              OHD_I2C_CTRL: begin
                next_i2c_dc = sh[6];
                next_i2c_cont = sh[7];
                next_ist = OHD_I2C_DATA;
              end
              OHD_I2C_DATA: begin
                byte_stb = 1'b1;
                if (i2c_cont) next_ist = OHD_I2C_CTRL;
              end
              default: next_ist = OHD_I2C_IDLE;
            endcase
          end else if (ack) begin
            next_ack = 1'b0;
            next_cnt = '0;
          end
        end
      end
    endcase
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh <= '0;
      cnt <= '0;
      ist <= OHD_I2C_IDLE;
      ack <= 1'b0;
      i2c_dc <= 1'b0;
      i2c_cont <= 1'b0;
    end else begin
      sh <= next_sh;
      cnt <= next_cnt;
      ist <= next_ist;
      ack <= next_ack;
      i2c_dc <= next_i2c_dc;
      i2c_cont <= next_i2c_cont;
    end
  end
  // Only ACK is driven; read-back of status is not supported
  assign sda_out_o = 1'b0;
  assign sda_out_oe_o = ack;
  assign bus_lines_o = 8'h00;
  assign bus_lines_oe_o = 1'b0;

  // Data bytes go to the stream; a full FIFO drops the byte
  logic dat_ready;
  ohd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(byte_stb && byte_dc),
    .in_ready_o(dat_ready),
    .in_data_i(byte_val),
    .out_valid_o(pix_valid_o),
    .out_ready_i(pix_ready_i),
    .out_data_o(pix_data_o)
  );

  // Command decoder
  logic cmd_stb;
  logic [7:0] op, next_op;
  logic [2:0] pidx, next_pidx;
  logic [1:0] next_mode;
  logic [7:0] next_pcs, next_cs, next_ce, next_con, next_bri;
  logic [2:0] next_ps, next_pe;
  logic [5:0] next_sl, next_l0, next_la, next_lb, next_lc;
  logic [63:0] next_bank;
  assign cmd_stb = byte_stb && !byte_dc;
  always_comb begin
    next_op = op;
    next_pidx = pidx;
    next_mode = addr_mode_o;
    next_pcs = page_col_start_o;
    next_cs = col_start_o;
    next_ce = col_end_o;
    next_ps = page_start_o;
    next_pe = page_end_o;
    next_sl = start_line_o;
    next_con = contrast_o;
    next_bri = brightness_o;
    next_l0 = lut_bank0_o;
    next_la = lut_color_a_o;
    next_lb = lut_color_b_o;
    next_lc = lut_color_c_o;
    next_bank = bank_color_o;
    if (cmd_stb && pidx != 3'h0) begin
      next_pidx = pidx - 3'h1;
      unique case (op)
        `OHD_CMD_MODE:
          if (byte_val[1:0] != 2'h3) next_mode = byte_val[1:0];
        `OHD_CMD_COLS:
          if (pidx == 3'h2) next_cs = byte_val;
          else next_ce = byte_val;
        `OHD_CMD_PAGES:
          if (pidx == 3'h2) next_ps = byte_val[2:0];
          else next_pe = byte_val[2:0];
        `OHD_CMD_CONTRAST: next_con = byte_val;
        `OHD_CMD_BRIGHT: next_bri = byte_val;
        `OHD_CMD_LUT:
          unique case (pidx)
            3'h4: next_l0 = byte_val[5:0];
            3'h3: next_la = byte_val[5:0];
            3'h2: next_lb = byte_val[5:0];
            default: next_lc = byte_val[5:0];
          endcase
        `OHD_CMD_BANK_LO:
          next_bank[8*(4-pidx) +: 8] = byte_val;
        default:
          next_bank[32 + 8*(4-pidx) +: 8] = byte_val;
      endcase
    end else if (cmd_stb) begin
      next_op = byte_val;
      if (byte_val[7:4] == 4'h0) begin
        next_pcs = {page_col_start_o[7:4], byte_val[3:0]};
      end else if (byte_val[7:4] == 4'h1) begin
        next_pcs = {byte_val[3:0], page_col_start_o[3:0]};
      end else if (byte_val[7:6] == 2'h1) begin
        next_sl = byte_val[5:0];
      end else begin
        unique case (byte_val)
          `OHD_CMD_MODE, `OHD_CMD_CONTRAST, `OHD_CMD_BRIGHT: next_pidx = 3'h1;
          `OHD_CMD_COLS, `OHD_CMD_PAGES: next_pidx = 3'h2;
          `OHD_CMD_LUT, `OHD_CMD_BANK_LO, `OHD_CMD_BANK_HI: next_pidx = 3'h4;
          default: next_pidx = 3'h0;
        endcase
      end
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op <= '0;
      pidx <= '0;
      addr_mode_o <= `OHD_RST_MODE;
      page_col_start_o <= '0;
      col_start_o <= '0;
      col_end_o <= `OHD_RST_COL_END;
      page_start_o <= '0;
      page_end_o <= `OHD_RST_PAGE_END;
      start_line_o <= '0;
      contrast_o <= `OHD_RST_LEVEL;
      brightness_o <= `OHD_RST_LEVEL;
      lut_bank0_o <= `OHD_RST_LUT_BANK0;
      lut_color_a_o <= `OHD_RST_LUT_COLOR;
      lut_color_b_o <= `OHD_RST_LUT_COLOR;
      lut_color_c_o <= `OHD_RST_LUT_COLOR;
      bank_color_o <= '0;
    end else begin
      op <= next_op;
      pidx <= next_pidx;
      addr_mode_o <= next_mode;
      page_col_start_o <= next_pcs;
      col_start_o <= next_cs;
      col_end_o <= next_ce;
      page_start_o <= next_ps;
      page_end_o <= next_pe;
      start_line_o <= next_sl;
      contrast_o <= next_con;
      brightness_o <= next_bri;
      lut_bank0_o <= next_l0;
      lut_color_a_o <= next_la;
      lut_color_b_o <= next_lb;
      lut_color_c_o <= next_lc;
      bank_color_o <= next_bank;
    end
  end
  assign lut_color_d_o = `OHD_COLOR_D_WIDTH;
endmodule : ohd_decoder

// ---- tb/ohd_decoder_monitor.sv ----
// Concurrent checks on the decoder's pins, attached by bind.
// Assumes the straps stay still while a host port is in use.
`timescale 1ns/1ps
module ohd_decoder_monitor (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic chip_sel_n_i,
  input wire logic cmd_data_i,
  input wire logic port_strap_lo_i,
  input wire logic port_strap_hi_i,
  input wire logic pix_valid_o,
  input wire logic pix_ready_i,
  input wire logic [7:0] pix_data_o,
  input wire logic [1:0] addr_mode_o,
  input wire logic [7:0] page_col_start_o,
  input wire logic [7:0] contrast_o,
  input wire logic [5:0] start_line_o,
  input wire logic [6:0] lut_color_d_o,
  input wire logic sda_out_oe_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_rst_vals;
    $rose(rst_n_i) |-> contrast_o == 8'h80 && addr_mode_o == 2'h2;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("defaults missing after reset");
  property p_color_d;
    lut_color_d_o == 7'h40;
  endproperty
  a_color_d: assert property (p_color_d)
    else $error("colour D width not 64");
  property p_mode_ok;
    addr_mode_o != 2'h3;
  endproperty
  a_mode_ok: assert property (p_mode_ok)
    else $error("invalid addressing mode taken");
  // Pin levels two clocks back still belong to the byte that caused it
  property p_cmd_dc;
    ($changed(contrast_o) || $changed(addr_mode_o)
      || $changed(page_col_start_o)) |-> !$past(cmd_data_i, 2);
  endproperty
  a_cmd_dc: assert property (p_cmd_dc)
    else $error("setting changed by a data byte");
  property p_cmd_cs;
    ($changed(contrast_o) || $changed(start_line_o))
      |-> !$past(chip_sel_n_i, 2);
  endproperty
  a_cmd_cs: assert property (p_cmd_cs)
    else $error("setting changed while deselected");
  property p_pix_dc;
    $rose(pix_valid_o) |-> $past(cmd_data_i, 2)
      && !$past(chip_sel_n_i, 2);
  endproperty
  a_pix_dc: assert property (p_pix_dc)
    else $error("pixel byte without data select");
  property p_pix_hold;
    pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_data_o);
  endproperty
  a_pix_hold: assert property (p_pix_hold)
    else $error("pixel byte dropped while stalled");
  property p_sda_oe;
    sda_out_oe_o |-> port_strap_lo_i && !port_strap_hi_i;
  endproperty
  a_sda_oe: assert property (p_sda_oe)
    else $error("acknowledge driven outside two-wire port");
endmodule : ohd_decoder_monitor
bind ohd_decoder ohd_decoder_monitor mon_u (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .chip_sel_n_i(chip_sel_n_i),
  .cmd_data_i(cmd_data_i), .port_strap_lo_i(port_strap_lo_i),
  .port_strap_hi_i(port_strap_hi_i), .pix_valid_o(pix_valid_o),
  .pix_ready_i(pix_ready_i), .pix_data_o(pix_data_o),
  .addr_mode_o(addr_mode_o), .page_col_start_o(page_col_start_o),
  .contrast_o(contrast_o), .start_line_o(start_line_o),
  .lut_color_d_o(lut_color_d_o), .sda_out_oe_o(sda_out_oe_o));

// ---- tb/ohd_host_model.sv ----
// Host processor model: writes one byte at a time on the strapped port.
// Assumes the bench sets the straps before a transfer starts.
`timescale 1ns/1ps
module ohd_host_model (
  input wire logic clock_i,
  input wire logic strap_hi_i,
  input wire logic strap_lo_i,
  output logic cs_n_o,
  output logic dc_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] bus_o
);
  initial begin
    cs_n_o = 1'b1;
    dc_o = 1'b0;
    wr_o = 1'b1;
    rd_o = 1'b1;
    bus_o = 8'h00;
  end
  // A 6800 read request must be ignored, so it doubles as a refusal test
  task put(input logic dc, input logic [7:0] b, input logic rd_req);
    @(negedge clock_i);
    wr_o = strap_hi_i & (strap_lo_i | rd_req);
    rd_o = strap_hi_i & strap_lo_i;
    repeat (4) @(negedge clock_i);
    cs_n_o = 1'b0;
    dc_o = dc;
    if (strap_hi_i) begin
      bus_o = b;
      repeat (2) @(negedge clock_i);
      if (strap_lo_i) begin
        wr_o = 1'b0;
      end else begin
        rd_o = 1'b1;
      end
      repeat (4) @(negedge clock_i);
      wr_o = wr_o | strap_lo_i;
      rd_o = rd_o & strap_lo_i;
      repeat (6) @(negedge clock_i);
    end else begin
      for (int i = 7; i >= 0; i--) begin
        bus_o = {6'h00, b[i], 1'b0};
        repeat (4) @(negedge clock_i);
        bus_o[0] = 1'b1;
        repeat (4) @(negedge clock_i);
      end
      bus_o[0] = 1'b0;
      repeat (4) @(negedge clock_i);
    end
    // Released lines show stale data inverted, never the last value
    cs_n_o = 1'b1;
    dc_o = ~dc;
    bus_o = strap_hi_i ? ~b : {6'h00, ~b[0], 1'b0};
  endtask : put
endmodule : ohd_host_model

// ---- tb/ohd_decoder_tb.sv ----
// Self-checking bench for the display command decoder.
// Assumes the host model owns the pins; two-wire port is not exercised.
`timescale 1ns/1ps
module ohd_decoder_tb;
  logic clk, rst_n, s_lo, s_hi, rdy, cs_n, dc, wr, rd, pv;
  logic [7:0] bus, pd, pcol, c_st, c_end, con, bri;
  logic [1:0] mode;
  logic [2:0] p_st, p_end;
  logic [5:0] sl, l0, la, lb, lc;
  logic [6:0] ld;
  logic [63:0] banks;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  ohd_host_model host_u (.clock_i(clk), .strap_hi_i(s_hi),
    .strap_lo_i(s_lo), .cs_n_o(cs_n), .dc_o(dc), .wr_o(wr),
    .rd_o(rd), .bus_o(bus));
  ohd_decoder #(.FIFO_DEPTH(8)) dut_u (.clock_i(clk), .rst_n_i(rst_n),
    .port_strap_lo_i(s_lo), .port_strap_hi_i(s_hi), .chip_sel_n_i(cs_n),
    .cmd_data_i(dc), .addr_lsb_pin_i(1'b0), .wr_pin_i(wr), .rd_pin_i(rd),
    .bus_lines_i(bus), .bus_lines_o(), .bus_lines_oe_o(), .sda_out_o(),
    .sda_out_oe_o(), .pix_valid_o(pv), .pix_ready_i(rdy), .pix_data_o(pd),
    .addr_mode_o(mode), .page_col_start_o(pcol), .col_start_o(c_st),
    .col_end_o(c_end), .page_start_o(p_st), .page_end_o(p_end),
    .start_line_o(sl), .contrast_o(con), .brightness_o(bri),
    .lut_bank0_o(l0), .lut_color_a_o(la), .lut_color_b_o(lb),
    .lut_color_c_o(lc), .lut_color_d_o(ld), .bank_color_o(banks));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task report_and_stop;
    $display("Checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task send(input logic d, input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) host_u.put(d, v[8*i+:8], 1'b0);
    repeat (4) @(negedge clk);
  endtask : send
  task pull(input logic [7:0] e);
    for (int n = 0; n < 50 && pv !== 1'b1; n++) @(negedge clk);
    chk({pv, pd}, {1'b1, e});
    rdy = 1'b1;
    @(negedge clk);
    rdy = 1'b0;
  endtask : pull
  task set_port(input logic hi, input logic lo);
    @(negedge clk);
    s_hi = hi;
    s_lo = lo;
    repeat (4) @(negedge clk);
  endtask : set_port
  task t_reset;
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk({mode, c_st, c_end}, 18'h20083);
    chk({p_st, p_end, con, bri}, 22'h78080);
    chk({l0, la, lb, lc, ld}, 31'h63FFFFC0);
    chk({pcol, sl, pv}, 15'h0);
    chk(banks, 64'h0);
  endtask : t_reset
  task t_8080;
    set_port(1'b1, 1'b1);
    send(1'b0, 48'h81C5_8211_2105, 6);
    send(1'b1, 8'h5A, 1);
    send(1'b0, 48'h7F_2003_0A13_7F, 6);
    chk({con, bri, c_st, c_end}, 32'hC511_057F);
    chk({mode, pcol, sl}, 16'h8EBF);
    pull(8'h5A);
    for (int m = 0; m < 3; m++) begin
      send(1'b0, {8'h20, 6'h3F, m[1:0]}, 2);
      chk(mode, m[1:0]);
    end
  endtask : t_8080
  task t_6800;
    set_port(1'b1, 1'b0);
    host_u.put(1'b0, 8'h81, 1'b1);
    host_u.put(1'b0, 8'h33, 1'b1);
    send(1'b0, 64'h22FB_FD91_1FFF_202A, 8);
    chk(con, 8'h80);
    chk({p_st, p_end}, 6'h1D);
    chk({l0, la, lb, lc}, 24'h7FF82A);
    send(1'b1, 8'hE7, 1);
    pull(8'hE7);
  endtask : t_6800
  task t_serial;
    set_port(1'b0, 1'b0);
    send(1'b0, 40'h92E4_1B00_FF, 5);
    send(1'b0, 40'h9301_0203_04, 5);
    send(1'b1, 8'hC3, 1);
    chk(banks, 64'h0403_0201_FF00_1BE4);
    pull(8'hC3);
  endtask : t_serial
  task t_fifo;
    set_port(1'b1, 1'b1);
    for (int i = 0; i < 9; i++) send(1'b1, 8'h10 + 8'(i), 1);
    for (int i = 0; i < 8; i++) pull(8'h10 + 8'(i));
    repeat (20) @(negedge clk);
    chk(pv, 1'b0);
  endtask : t_fifo
  initial begin
    rst_n = 1'b0;
    s_hi = 1'b1;
    s_lo = 1'b1;
    rdy = 1'b0;
    t_reset();
    t_8080();
    t_reset();
    t_6800();
    t_serial();
    t_fifo();
    report_and_stop();
  end
endmodule : ohd_decoder_tb
